// >>> src/mre_addr_gen.sv
`timescale 1ns/1ns
module mre_addr_gen
  import mre_pkg::*;
(
  // decode carrier
  mre_ctl_if.dec ctl
);

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  wire logic pageSel;
  wire logic [4:0] pageHi;

  // RL1 opcode and specifier
  assign ctl.opcode = ctl.instr[OPC_LSB +: OPC_W];
  assign ctl.memRef = (ctl.opcode != OPC_IO) && (ctl.opcode != OPC_OPR);

  // RL2 page zero or current page
  assign pageSel = ctl.instr[PAGE_BIT];
  assign pageHi = pageSel ? ctl.fetchPtr[WORD_W-1:PAGE_HI_LSB] : 5'h00;

  // RL3 low page bits
  assign ctl.pageLocal = {pageHi, ctl.instr[PAGE_LO_W-1:0]};

  // RL5 indirect select
  assign ctl.indirect = ctl.instr[IND_BIT];

  // RL8 autoindex by indirect bit and address only
  assign ctl.autoIdx = ctl.indirect &&
                       (ctl.pageLocal[WORD_W-1:AUTO_LSB] == AUTO_HI);

endmodule

// >>> src/mre_avalon_slave.sv
`timescale 1ns/1ns
module mre_avalon_slave
  import mre_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon slave
  input wire logic [AVS_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  // core carrier
  mre_ctl_if.bus ctl
);

  // ---------------------------------------------------------------
  // one wait state, then answer
  // ---------------------------------------------------------------
  logic ackQ;
  logic [31:0] rdDataQ;
  wire logic req = avsRead || avsWrite;
  wire logic wrFire = avsWrite && ackQ && (avsByteEnable[1:0] == 2'b11);
  wire logic [31:0] rdMux;
  wire logic hitCtrl = (avsAddress == REG_CTRL);
  wire logic hitAcc = (avsAddress == REG_ACC);
  wire logic hitPtr = (avsAddress == REG_PTR);
  wire logic hitField = (avsAddress == REG_FIELD);

  assign avsWaitrequest = req && !ackQ;
  assign avsReadData = rdDataQ;

  assign rdMux =
    (avsAddress == REG_STATUS) ? {30'h0, ctl.link, ctl.busy} :
    hitAcc ? {20'h0, ctl.acc} :
    hitPtr ? {20'h0, ctl.ptr} :
    hitField ? {21'h0, ctl.codeField, 1'b0, ctl.pending, 1'b0,
                ctl.operandField} :
    (avsAddress == REG_INSTR) ? {20'h0, ctl.instr} :
    32'h0;

  // ---------------------------------------------------------------
  // command strobes at the answering edge
  // ---------------------------------------------------------------
  assign ctl.start = wrFire && hitCtrl && avsWriteData[CTRL_START_BIT];
  assign ctl.accWr = wrFire && hitAcc;
  assign ctl.ptrWr = wrFire && hitPtr;
  assign ctl.fieldWr = wrFire && hitField;
  assign ctl.wrData = avsWriteData[WORD_W-1:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ackQ <= 1'b0;
      rdDataQ <= 32'h0;
    end else begin
      ackQ <= req && !ackQ;
      if (avsRead && !ackQ) begin
        rdDataQ <= rdMux;
      end
    end
  end

endmodule

// >>> src/mre_ctl_if.sv
`timescale 1ns/1ns
interface mre_ctl_if;
  import mre_pkg::*;
  // bus commands
  logic start;
  logic accWr;
  logic ptrWr;
  logic fieldWr;
  logic [WORD_W-1:0] wrData;
  // core state
  logic busy;
  logic link;
  logic [WORD_W-1:0] acc;
  logic [WORD_W-1:0] ptr;
  logic [WORD_W-1:0] instr;
  logic [FIELD_W-1:0] codeField;
  logic [FIELD_W-1:0] pending;
  logic [FIELD_W-1:0] operandField;
  // decode
  logic [WORD_W-1:0] fetchPtr;
  logic [OPC_W-1:0] opcode;
  logic [WORD_W-1:0] pageLocal;
  logic indirect;
  logic autoIdx;
  logic memRef;

  modport bus (output start, accWr, ptrWr, fieldWr, wrData,
               input busy, link, acc, ptr, instr, codeField, pending,
               operandField);
  modport core (input start, accWr, ptrWr, fieldWr, wrData,
                output busy, link, acc, ptr, instr, codeField, pending,
                operandField, fetchPtr,
                input opcode, pageLocal, indirect, autoIdx, memRef);
  modport dec (input instr, fetchPtr,
               output opcode, pageLocal, indirect, autoIdx, memRef);
endinterface

// >>> src/mre_executor.sv
// Operation
// RL1 - top three bits are opcode, low nine bits address specifier
// RL2 - page bit zero forces high five bits zero, else fetch pointer
// RL3 - low seven address bits come straight from instruction
// RL4 - code field prefixes the twelve bit address to fifteen bits
// RL5 - indirect bit set reads pointer word as operand address
// RL6 - pointer read from code field, operand from operand field
// RL7 - page zero 0010-0017 pointers incremented, written back, then used
// RL8 - autoindex applies on indirect reference whatever the page bit
// RL9 - operand write shows operand field on extended address lines
// RL10 - opcode 0 ands memory word into operand register
// RL11 - opcode 1 adds word, carry out inverts link
// RL12 - opcode 2 increments word, writes back, skips on zero
// RL13 - opcode 3 stores operand register then clears it
// RL14 - opcode 4 loads code field, stores pointer, jumps past target
// RL15 - opcode 5 loads code field and jumps to target
// RL16 - every fetch increments instruction pointer by one
// RL17 - pending field enters code field only at jump or call
// RL18 - opcodes 6 and 7 go to other decoders, no memory access
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
module mre_executor
  import mre_pkg::*;
#(
  parameter int WORD_BITS = WORD_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon slave
  input wire logic [AVS_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  // memory
  output logic memReq,
  output logic memWe,
  output logic [ADDR_W-1:0] memAddr,
  output logic [WORD_W-1:0] memWrData,
  input wire logic [WORD_W-1:0] memRdData,
  input wire logic memAck,
  // extended address lines
  output logic extFieldHiLine,
  output logic extFieldMidLine,
  output logic extFieldLowLine,
  // hand-off to other decoders
  output logic ioOpValid,
  output logic [WORD_W-1:0] ioOpWord
);

  if (WORD_BITS != WORD_W) begin : g_chk
    $error("mre_executor supports only a twelve bit word");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_PTR_RD, ST_PTR_WB,
    ST_EXEC, ST_OPR_RD, ST_OPR_WR
  } mre_state_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mre_state_t stateQ, stateD;
  logic [WORD_W-1:0] accQ, accD;
  logic linkQ, linkD;
  logic [WORD_W-1:0] ptrQ, ptrD;
  logic [WORD_W-1:0] instrQ, instrD;
  logic [WORD_W-1:0] fetchPtrQ, fetchPtrD;
  logic [WORD_W-1:0] eaQ, eaD;
  logic [WORD_W-1:0] wdQ, wdD;
  logic [FIELD_W-1:0] cfQ, cfD;
  logic [FIELD_W-1:0] pendQ, pendD;
  logic [FIELD_W-1:0] ofQ, ofD;
  logic ioValidQ, ioValidD;
  logic [WORD_W-1:0] ioWordQ, ioWordD;
  logic [WORD_W:0] sum;

  mre_ctl_if ctl ();

  mre_avalon_slave u_slave (
    .core_clk(core_clk),
    .rst(rst),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest),
    .ctl(ctl.bus)
  );

  mre_addr_gen u_dec (
    .ctl(ctl.dec)
  );

  assign ctl.busy = (stateQ != ST_IDLE);
  assign ctl.link = linkQ;
  assign ctl.acc = accQ;
  assign ctl.ptr = ptrQ;
  assign ctl.instr = instrQ;
  assign ctl.fetchPtr = fetchPtrQ;
  assign ctl.codeField = cfQ;
  assign ctl.pending = pendQ;
  assign ctl.operandField = ofQ;

  // ---------------------------------------------------------------
  // memory side selection
  // ---------------------------------------------------------------
  wire logic inPtr = (stateQ == ST_PTR_RD) || (stateQ == ST_PTR_WB);
  wire logic inOpr = (stateQ == ST_OPR_RD) || (stateQ == ST_OPR_WR);
  // RL6 operand field only for indirect
  wire logic [FIELD_W-1:0] oprField = ctl.indirect ? ofQ : cfQ;
  wire logic [FIELD_W-1:0] extField;

  assign memReq = (stateQ == ST_FETCH) || inPtr || inOpr;
  assign memWe = (stateQ == ST_PTR_WB) || (stateQ == ST_OPR_WR);
  // RL4 field prefix on every address
  assign memAddr = inPtr ? {cfQ, ctl.pageLocal} :
                   inOpr ? {oprField, eaQ} :
                   {cfQ, ptrQ};
  assign memWrData = wdQ;
  // RL9 operand field on operand write
  assign extField = (stateQ == ST_OPR_WR) ? ofQ : memAddr[ADDR_W-1:WORD_W];
  assign extFieldHiLine = extField[2];
  assign extFieldMidLine = extField[1];
  assign extFieldLowLine = extField[0];
  assign ioOpValid = ioValidQ;
  assign ioOpWord = ioWordQ;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    accD = accQ;
    linkD = linkQ;
    ptrD = ptrQ;
    instrD = instrQ;
    fetchPtrD = fetchPtrQ;
    eaD = eaQ;
    wdD = wdQ;
    cfD = cfQ;
    pendD = pendQ;
    ofD = ofQ;
    ioValidD = 1'b0;
    ioWordD = ioWordQ;
    sum = {1'b0, accQ} + {1'b0, memRdData};
    case (stateQ)
      ST_IDLE: begin
        if (ctl.accWr) begin
          accD = ctl.wrData;
        end
        if (ctl.ptrWr) begin
          ptrD = ctl.wrData;
        end
        if (ctl.fieldWr) begin
          pendD = ctl.wrData[FLD_PEND_LSB +: FIELD_W];
          ofD = ctl.wrData[FLD_OPER_LSB +: FIELD_W];
        end
        if (ctl.start) begin
          stateD = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (memAck) begin
          instrD = memRdData;
          fetchPtrD = ptrQ;
          // RL16 advance on fetch
          ptrD = ptrQ + 12'h001;
          stateD = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // RL18 hand off without memory access
        if (!ctl.memRef) begin
          ioValidD = 1'b1;
          ioWordD = instrQ;
          stateD = ST_IDLE;
        end else if (ctl.indirect) begin
          stateD = ST_PTR_RD;
        end else begin
          // RL5 direct address
          eaD = ctl.pageLocal;
          stateD = ST_EXEC;
        end
      end
      ST_PTR_RD: begin
        if (memAck) begin
          // RL7 increment before use
          if (ctl.autoIdx) begin
            wdD = memRdData + 12'h001;
            stateD = ST_PTR_WB;
          end else begin
            eaD = memRdData;
            stateD = ST_EXEC;
          end
        end
      end
      ST_PTR_WB: begin
        if (memAck) begin
          eaD = wdQ;
          stateD = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (ctl.opcode)
          OPC_DCA: begin
            wdD = accQ;
            stateD = ST_OPR_WR;
          end
          // RL17 pending field taken at call
          OPC_CALL: begin
            cfD = pendQ;
            wdD = ptrQ;
            stateD = ST_OPR_WR;
          end
          // RL15 pending field and jump
          OPC_GOTO: begin
            cfD = pendQ;
            ptrD = eaQ;
            stateD = ST_IDLE;
          end
          default: begin
            stateD = ST_OPR_RD;
          end
        endcase
      end
      ST_OPR_RD: begin
        if (memAck) begin
          stateD = ST_IDLE;
          case (ctl.opcode)
            // RL10 and into register
            OPC_AND: begin
              accD = accQ & memRdData;
            end
            // RL11 add with link flip
            OPC_ADD: begin
              accD = sum[WORD_W-1:0];
              linkD = linkQ ^ sum[WORD_W];
            end
            default: begin
              wdD = memRdData + 12'h001;
              stateD = ST_OPR_WR;
            end
          endcase
        end
      end
      ST_OPR_WR: begin
        if (memAck) begin
          stateD = ST_IDLE;
          case (ctl.opcode)
            // RL12 skip on zero
            OPC_ISZ: begin
              if (wdQ == RST_WORD) begin
                ptrD = ptrQ + 12'h001;
              end
            end
            // RL13 clear after store
            OPC_DCA: begin
              accD = RST_WORD;
            end
            // RL14 return past target
            default: begin
              ptrD = eaQ + 12'h001;
            end
          endcase
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateQ <= ST_IDLE;
      accQ <= RST_WORD;
      linkQ <= 1'b0;
      ptrQ <= RST_WORD;
      instrQ <= RST_WORD;
      fetchPtrQ <= RST_WORD;
      eaQ <= RST_WORD;
      wdQ <= RST_WORD;
      cfQ <= RST_FIELD;
      pendQ <= RST_FIELD;
      ofQ <= RST_FIELD;
      ioValidQ <= 1'b0;
      ioWordQ <= RST_WORD;
    end else begin
      stateQ <= stateD;
      accQ <= accD;
      linkQ <= linkD;
      ptrQ <= ptrD;
      instrQ <= instrD;
      fetchPtrQ <= fetchPtrD;
      eaQ <= eaD;
      wdQ <= wdD;
      cfQ <= cfD;
      pendQ <= pendD;
      ofQ <= ofD;
      ioValidQ <= ioValidD;
      ioWordQ <= ioWordD;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire logic rdAck = memAck && (stateQ == ST_OPR_RD);
  wire logic wrAck = memAck && (stateQ == ST_OPR_WR);

  a_opcode_split: assert property ( // RL1
    ctl.opcode == instrQ[11:9])
    else $error("opcode not from top bits");
  a_page_zero: assert property ( // RL2
    !instrQ[PAGE_BIT] |-> ctl.pageLocal[11:7] == 5'h00)
    else $error("page zero not forced");
  a_page_low: assert property ( // RL3
    ctl.pageLocal[6:0] == instrQ[6:0] &&
    (!instrQ[PAGE_BIT] || ctl.pageLocal[11:7] == fetchPtrQ[11:7]))
    else $error("page local address wrong");
  a_fetch_field: assert property ( // RL4
    stateQ == ST_FETCH |-> memAddr == {cfQ, ptrQ})
    else $error("fetch address not field prefixed");
  a_direct_ea: assert property ( // RL5
    stateQ == ST_DECODE && ctl.memRef && !ctl.indirect
    |=> stateQ == ST_EXEC && eaQ == $past(ctl.pageLocal))
    else $error("direct address not page local");
  a_ptr_field: assert property ( // RL6
    stateQ == ST_PTR_RD |-> memAddr == {cfQ, ctl.pageLocal} && !memWe)
    else $error("pointer read address wrong");
  a_auto_wb: assert property ( // RL7
    stateQ == ST_PTR_RD && memAck && ctl.autoIdx
    |=> stateQ == ST_PTR_WB && memWe &&
        memWrData == $past(memRdData) + 12'h001)
    else $error("autoindex write back wrong");
  a_auto_page: assert property ( // RL8
    stateQ == ST_DECODE && ctl.indirect && instrQ[7:3] == 5'h01
    |-> ctl.autoIdx)
    else $error("autoindex missed");
  a_ext_lines: assert property ( // RL9
    stateQ == ST_OPR_WR |->
    {extFieldHiLine, extFieldMidLine, extFieldLowLine} == ofQ)
    else $error("operand field not on lines");
  a_and_op: assert property ( // RL10
    rdAck && ctl.opcode == OPC_AND
    |=> accQ == ($past(accQ) & $past(memRdData)) && !memReq)
    else $error("and result wrong");
  a_add_link: assert property ( // RL11
    rdAck && ctl.opcode == OPC_ADD
    |=> {linkQ ^ $past(linkQ), accQ} ==
        {1'b0, $past(accQ)} + {1'b0, $past(memRdData)})
    else $error("add or link wrong");
  a_isz_skip: assert property ( // RL12
    wrAck && ctl.opcode == OPC_ISZ
    |=> ptrQ == $past(ptrQ) + ($past(wdQ) == 12'h000 ? 12'h001 : 12'h000))
    else $error("skip wrong");
  a_dca_clear: assert property ( // RL13
    wrAck && ctl.opcode == OPC_DCA
    |-> memWrData == accQ ##1 accQ == 12'h000)
    else $error("store and clear wrong");
  a_call_ret: assert property ( // RL14
    wrAck && ctl.opcode == OPC_CALL |=> ptrQ == $past(eaQ) + 12'h001)
    else $error("call return wrong");
  a_goto_tgt: assert property ( // RL15
    stateQ == ST_EXEC && ctl.opcode == OPC_GOTO
    |=> ptrQ == $past(eaQ) && cfQ == $past(pendQ) && $stable(accQ))
    else $error("jump wrong");
  a_fetch_incr: assert property ( // RL16
    stateQ == ST_FETCH && memAck |=> ptrQ == $past(ptrQ) + 12'h001)
    else $error("pointer not advanced");
  a_field_hold: assert property ( // RL17
    !(stateQ == ST_EXEC && (ctl.opcode == OPC_CALL ||
      ctl.opcode == OPC_GOTO)) |=> $stable(cfQ))
    else $error("code field changed");
  a_io_route: assert property ( // RL18
    stateQ == ST_DECODE && !ctl.memRef
    |=> ioOpValid && stateQ == ST_IDLE && !memReq)
    else $error("io op not routed");

  c_auto_index: cover property (stateQ == ST_PTR_WB && memAck);
  c_isz_skip: cover property (wrAck && ctl.opcode == OPC_ISZ &&
                              wdQ == 12'h000);
  c_call: cover property (wrAck && ctl.opcode == OPC_CALL);
  c_io_route: cover property (ioOpValid);

endmodule

// >>> src/mre_pkg.sv
package mre_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WORD_W = 12;
  localparam int FIELD_W = 3;
  localparam int ADDR_W = 15;
  localparam int OPC_W = 3;

  // ---------------------------------------------------------------
  // instruction word layout (lsb numbering)
  // ---------------------------------------------------------------
  localparam int OPC_LSB = 9;
  localparam int IND_BIT = 8;
  localparam int PAGE_BIT = 7;
  localparam int PAGE_HI_LSB = 7;
  localparam int PAGE_LO_W = 7;
  localparam int AUTO_LSB = 3;
  localparam logic [8:0] AUTO_HI = 9'h001;

  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  localparam logic [2:0] OPC_AND = 3'h0;
  localparam logic [2:0] OPC_ADD = 3'h1;
  localparam logic [2:0] OPC_ISZ = 3'h2;
  localparam logic [2:0] OPC_DCA = 3'h3;
  localparam logic [2:0] OPC_CALL = 3'h4;
  localparam logic [2:0] OPC_GOTO = 3'h5;
  localparam logic [2:0] OPC_IO = 3'h6;
  localparam logic [2:0] OPC_OPR = 3'h7;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int AVS_ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_ACC = 5'h08;
  localparam logic [4:0] REG_PTR = 5'h0c;
  localparam logic [4:0] REG_FIELD = 5'h10;
  localparam logic [4:0] REG_INSTR = 5'h14;

  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LINK_BIT = 1;
  localparam int FLD_OPER_LSB = 0;
  localparam int FLD_PEND_LSB = 4;
  localparam int FLD_CODE_LSB = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] RST_WORD = 12'h000;
  localparam logic [2:0] RST_FIELD = 3'h0;

endpackage

// >>> test/memory_reference_executor_test.sv
`timescale 1ns/1ns
module memory_reference_executor_test;
  import mre_pkg::*;
  // ---------------------------------------------------------------
  // wiring
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [AVS_ADDR_W-1:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitrequest;
  logic memReq, memWe, memAck, ioOpValid, extHi, extMid, extLow;
  logic [ADDR_W-1:0] memAddr;
  logic [WORD_W-1:0] memWrData, memRdData, ioOpWord;
  logic [31:0] rd;
  int nMismatch = 0;
  int numChecks = 0;
  int nIo = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (ioOpValid === 1'b1) nIo++;
  mre_executor u_dut (.core_clk(core_clk), .rst(rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
    .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData), .memAck(memAck),
    .extFieldHiLine(extHi), .extFieldMidLine(extMid),
    .extFieldLowLine(extLow), .ioOpValid(ioOpValid),
    .ioOpWord(ioOpWord));
  mre_mem_model u_mem (.core_clk(core_clk), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(memRdData), .memAck(memAck),
    .extField({extHi, extMid, extLow}));
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [14:0] got, input logic [14:0] exp,
                       input string what);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [11:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {20'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0);
    check(15'(n), 15'h2, "wait states");
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic reg_is(input logic [4:0] a, input logic [14:0] exp);
    bus(1'b0, a, 12'h000);
    check(rd[14:0], exp, "register");
  endtask
  task automatic run(input logic [11:0] pc, input logic [11:0] acc);
    bus(1'b1, REG_PTR, pc);
    bus(1'b1, REG_ACC, acc);
    bus(1'b1, REG_CTRL, 12'h001);
    do begin
      bus(1'b0, REG_STATUS, 12'h000);
    end while (rd[0] !== 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    reg_is(REG_ACC, 15'h0);
    reg_is(REG_PTR, 15'h0);
    reg_is(REG_FIELD, 15'h0);
    reg_is(REG_STATUS, 15'h0);
    reg_is(5'h1c, 15'h0);
    $display("reset test done");
  endtask
  task automatic t_and();
    int a0;
    a0 = u_mem.nAcc;
    u_mem.mem[15'h0300] = 12'h02d;
    u_mem.mem[15'h002d] = 12'h0f0;
    u_mem.mem[15'h032d] = 12'hfff;
    run(12'h300, 12'h3cc);
    reg_is(REG_ACC, 15'h0c0);
    reg_is(REG_INSTR, 15'h02d);
    reg_is(REG_PTR, 15'h301);
    check(15'(u_mem.mem[15'h002d]), 15'h0f0, "and mem");
    check(15'(u_mem.nAcc - a0), 15'h2, "and accesses");
    $display("and test done");
  endtask
  task automatic t_add();
    u_mem.lat = 3;
    u_mem.mem[15'h047f] = 12'h290;
    u_mem.mem[15'h0410] = 12'h002;
    u_mem.mem[15'h0490] = 12'h7ff;
    run(12'h47f, 12'hfff);
    reg_is(REG_ACC, 15'h001);
    reg_is(REG_STATUS, 15'h2);
    $display("add test done");
  endtask
  task automatic t_isz();
    for (int i = 0; i < 2; i++) begin
      u_mem.mem[15'h0500] = (i == 0) ? 12'h41b : 12'h59b;
      u_mem.mem[15'h051b] = 12'h01b;
      u_mem.mem[15'h001b] = (i == 0) ? 12'hfff : 12'h7fe;
      run(12'h500, 12'h000);
      check(15'(u_mem.mem[15'h001b]), (i == 0) ? 15'h0 : 15'h7ff,
            "count word");
      reg_is(REG_PTR, (i == 0) ? 15'h502 : 15'h501);
    end
    $display("count skip test done");
  endtask
  task automatic t_dca_auto();
    int a0;
    u_mem.lat = 1;
    bus(1'b1, REG_FIELD, 12'h003);
    a0 = u_mem.nAcc;
    u_mem.mem[15'h0020] = 12'h788;
    u_mem.mem[15'h0008] = 12'h1ff;
    run(12'h020, 12'h123);
    check(15'(u_mem.mem[15'h0008]), 15'h200, "pointer");
    check(15'(u_mem.mem[15'h3200]), 15'h123, "stored");
    check(15'(u_mem.wrExt), 15'h3, "ext lines");
    check(15'(u_mem.nAcc - a0), 15'h4, "dca accesses");
    reg_is(REG_ACC, 15'h0);
    $display("store clear test done");
  endtask
  task automatic t_call_goto();
    u_mem.lat = 0;
    bus(1'b1, REG_FIELD, 12'h023);
    u_mem.mem[15'h0100] = 12'h8a8;
    run(12'h100, 12'h456);
    check(15'(u_mem.mem[15'h2128]), 15'h101, "return addr");
    reg_is(REG_PTR, 15'h129);
    reg_is(REG_FIELD, 15'h223);
    reg_is(REG_ACC, 15'h456);
    bus(1'b1, REG_FIELD, 12'h053);
    u_mem.mem[15'h2129] = 12'ha3f;
    run(12'h129, 12'h456);
    reg_is(REG_PTR, 15'h03f);
    reg_is(REG_FIELD, 15'h553);
    reg_is(REG_ACC, 15'h456);
    $display("call goto test done");
  endtask
  task automatic t_handoff();
    int a0;
    int i0;
    for (int i = 0; i < 2; i++) begin
      a0 = u_mem.nAcc;
      i0 = nIo;
      u_mem.mem[15'h5040] = (i == 0) ? 12'hc05 : 12'he01;
      run(12'h040, 12'h0aa);
      check(15'(nIo - i0), 15'h1, "handoff pulse");
      check(15'(ioOpWord), (i == 0) ? 15'hc05 : 15'he01, "word");
      check(15'(u_mem.nAcc - a0), 15'h1, "handoff accesses");
      reg_is(REG_ACC, 15'h0aa);
    end
    $display("handoff test done");
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_and();
    t_add();
    t_isz();
    t_dca_auto();
    t_call_goto();
    t_handoff();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    stop_test();
  end
endmodule

// >>> test/mre_mem_model.sv
`timescale 1ns/1ns
module mre_mem_model
  import mre_pkg::*;
(
  // clock
  input wire logic core_clk,
  // memory access
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [WORD_W-1:0] memWrData,
  output logic [WORD_W-1:0] memRdData,
  output logic memAck,
  // extended address lines
  input wire logic [FIELD_W-1:0] extField
);
  // ---------------------------------------------------------------
  // storage, answer after lat idle cycles
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  int lat = 0;
  int waitCnt = 0;
  int nAcc = 0;
  logic [FIELD_W-1:0] wrExt = 3'h0;
  initial begin
    memRdData = 12'h5a5;
    memAck = 1'b0;
  end
  always @(posedge core_clk) begin
    if (memReq && !memAck && waitCnt >= lat) begin
      memAck <= 1'b1;
      memRdData <= memWe ? ~memRdData : mem[memAddr];
      waitCnt <= 0;
    end else begin
      // stale data never looks valid outside the ack cycle
      memAck <= 1'b0;
      memRdData <= ~memRdData;
      waitCnt <= (memReq && !memAck) ? waitCnt + 1 : 0;
    end
    if (memAck && memWe) begin
      mem[memAddr] <= memWrData;
      wrExt <= extField;
    end
    if (memAck) begin
      nAcc <= nAcc + 1;
    end
  end
endmodule
